// >>> inc/adcseq_defs.vh
`ifndef ADCSEQ_DEFS_VH
`define ADCSEQ_DEFS_VH

// -----------------------------------------------------------------------
// Register addresses.
// -----------------------------------------------------------------------
`define ADCSEQ_ADDR_CTRL 8'hE8
`define ADCSEQ_ADDR_CFG 8'hBC
`define ADCSEQ_ADDR_RES_HI 8'hBF
`define ADCSEQ_ADDR_RES_LO 8'hBE

// -----------------------------------------------------------------------
// Control register fields.
// -----------------------------------------------------------------------
`define ADCSEQ_CTRL_EN 7
`define ADCSEQ_CTRL_TM 6
`define ADCSEQ_CTRL_DONE 5
`define ADCSEQ_CTRL_BUSY 4
`define ADCSEQ_CTRL_SM_HI 3
`define ADCSEQ_CTRL_SM_LO 2
`define ADCSEQ_CTRL_LJ 0
`define ADCSEQ_CTRL_RST 8'h00
`define ADCSEQ_CTRL_WMASK 8'hED

// -----------------------------------------------------------------------
// Configuration register fields.
// -----------------------------------------------------------------------
`define ADCSEQ_CFG_DIV_HI 1
`define ADCSEQ_CFG_DIV_LO 0
`define ADCSEQ_CFG_RST 8'h00

// -----------------------------------------------------------------------
// Result, read-back and pin defaults.
// -----------------------------------------------------------------------
`define ADCSEQ_RES_HI_RST 8'h00
`define ADCSEQ_RES_LO_RST 8'h00
`define ADCSEQ_RD_UNMAPPED 8'h00
`define ADCSEQ_PIN_IDLE 1'h1

// -----------------------------------------------------------------------
// Start mode codes.
// -----------------------------------------------------------------------
`define ADCSEQ_SM_SW 2'h0
`define ADCSEQ_SM_T3 2'h1
`define ADCSEQ_SM_PIN 2'h2
`define ADCSEQ_SM_T2 2'h3

// -----------------------------------------------------------------------
// Timing figures.
// -----------------------------------------------------------------------
`define ADCSEQ_TRACK_SAR_CLKS 4'h3
`define ADCSEQ_CONV_SAR_CLKS 4'hC

`endif

// >>> hw/adcseq_divider.v
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------------
// Conversion clock divider: one tick every 2, 4, 8 or 16 system clocks.
// -----------------------------------------------------------------------
module adcseq_divider (
    input wire clk_i,
    input wire sys_rst_i,
    input wire run_i,
    input wire [1:0] div_sel_i,
    output reg tick_o
);

    reg [3:0] cnt_reg;
    reg [3:0] cnt_next;
    wire [3:0] last_w;

    // Terminal count is 2^(sel+1) - 1.
    assign last_w = (4'h2 << div_sel_i) - 4'h1;

    // Counter restarts whenever the sequencer is not running.
    always @* begin
        if (!run_i || cnt_reg >= last_w) begin
            cnt_next = 4'h0;
        end else begin
            cnt_next = cnt_reg + 4'h1;
        end
    end

    // Registers count and tick.
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_reg <= 4'h0;
            tick_o <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_o <= run_i && (cnt_reg == last_w);
        end
    end

endmodule // adcseq_divider

`default_nettype wire

// >>> hw/adcseq_top.v
// Notes on behaviour
// - Conversion clock is system clock divided by 2, 4, 8 or 16.
// - Start from software busy write, Timer 3, pin rising edge, or Timer 2.
// - Busy reads one through a conversion, zero once it completes.
// - Busy falling edge sets done flag and, if enabled, requests interrupt.
// - Result placed left or right justified by the justify bit.
// - Track-mode zero tracks continuously except during conversion.
// - Track-mode one uses low-power tracking chosen by start mode.
// - Low-power software or timer start tracks 3 SAR clocks first.
// - Low-power pin mode tracks while pin is low, holds while high.
// - Tracking shuts down entirely during chip standby or sleep.
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_defs.vh"

module adcseq_top #(
    parameter RES_W = 10,
    parameter CONV_CLKS = 12
) (
    input wire clk_i,
    input wire sys_rst_i,
    input wire sfr_wr_i,
    input wire sfr_rd_i,
    input wire [7:0] sfr_addr_i,
    input wire [7:0] sfr_wdata_i,
    output reg [7:0] sfr_rdata_o,
    input wire irq_enable_i,
    output wire irq_req_o,
    input wire timer2_ovf_i,
    input wire timer3_ovf_i,
    input wire convert_start_pin_i,
    input wire chip_sleep_i,
    output reg track_o,
    output reg sample_start_o,
    output reg sar_tick_o,
    input wire [RES_W-1:0] sar_result_i,
    input wire sar_result_valid_i
);

    // Sequencer states: waiting, timed low-power tracking, converting.
    localparam ST_IDLE = 2'h0;
    localparam ST_TRACK = 2'h1;
    localparam ST_CONV = 2'h2;

    // -------------------------------------------------------------------
    // Registers and signals.
    // -------------------------------------------------------------------
    reg [7:0] converter_control_reg;
    reg [7:0] converter_config_reg;
    reg [7:0] result_high_reg;
    reg [7:0] result_low_reg;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [3:0] cnt_reg;
    reg [3:0] cnt_next;
    reg busy_q_reg;
    reg pin_s1_reg;
    reg pin_s2_reg;
    reg pin_s3_reg;
    reg sleep_s1_reg;
    reg sleep_s2_reg;
    reg [7:0] res_hi_next;
    reg [7:0] res_lo_next;
    reg trigger;
    wire sar_tick;
    wire enable_w;
    wire track_mode_select;
    wire [1:0] start_mode_select;
    wire left_justify;
    wire convert_busy;
    wire [1:0] conv_clock_divide;
    wire wr_ctrl;
    wire wr_cfg;
    wire wr_res_hi;
    wire wr_res_lo;
    wire busy_fall;
    wire pin_rise;

    // Write strobe decode, shared by every register that software loads.
    function wr_hit;
        input wr;
        input [7:0] addr;
        input [7:0] target;
        begin
            wr_hit = wr && (addr == target);
        end
    endfunction

    // Control fields, write decodes and the edges that drive the sequencer.
    assign enable_w = converter_control_reg[`ADCSEQ_CTRL_EN];
    assign track_mode_select = converter_control_reg[`ADCSEQ_CTRL_TM];
    assign start_mode_select =
        converter_control_reg[`ADCSEQ_CTRL_SM_HI:`ADCSEQ_CTRL_SM_LO];
    assign left_justify = converter_control_reg[`ADCSEQ_CTRL_LJ];
    assign convert_busy = (state_reg != ST_IDLE);
    assign conv_clock_divide =
        converter_config_reg[`ADCSEQ_CFG_DIV_HI:`ADCSEQ_CFG_DIV_LO];
    assign wr_ctrl = wr_hit(sfr_wr_i, sfr_addr_i, `ADCSEQ_ADDR_CTRL);
    assign wr_cfg = wr_hit(sfr_wr_i, sfr_addr_i, `ADCSEQ_ADDR_CFG);
    assign wr_res_hi = wr_hit(sfr_wr_i, sfr_addr_i, `ADCSEQ_ADDR_RES_HI);
    assign wr_res_lo = wr_hit(sfr_wr_i, sfr_addr_i, `ADCSEQ_ADDR_RES_LO);
    assign busy_fall = busy_q_reg && !convert_busy;
    assign pin_rise = pin_s2_reg && !pin_s3_reg;

    // -------------------------------------------------------------------
    // Synchronise the external pin and the sleep level.
    // -------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            // Start at the idle level, so a pin resting high gives no false
            // rising edge when reset lets go.
            pin_s1_reg <= `ADCSEQ_PIN_IDLE;
            pin_s2_reg <= `ADCSEQ_PIN_IDLE;
            pin_s3_reg <= `ADCSEQ_PIN_IDLE;
            sleep_s1_reg <= 1'b0;
            sleep_s2_reg <= 1'b0;
        end else begin
            pin_s1_reg <= convert_start_pin_i;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            sleep_s1_reg <= chip_sleep_i;
            sleep_s2_reg <= sleep_s1_reg;
        end
    end

    // -------------------------------------------------------------------
    // SAR clock divider.
    // -------------------------------------------------------------------
    // It runs only while busy, so each busy span, track phase included, starts a fresh period.
    adcseq_divider u_div (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .run_i(convert_busy),
        .div_sel_i(conv_clock_divide),
        .tick_o(sar_tick)
    );

    // -------------------------------------------------------------------
    // Trigger selection.
    // -------------------------------------------------------------------
    // A trigger counts only while idle; one that comes while busy is lost.
    always @* begin
        case (start_mode_select)
            `ADCSEQ_SM_SW: trigger = wr_ctrl &&
                sfr_wdata_i[`ADCSEQ_CTRL_BUSY];
            `ADCSEQ_SM_T3: trigger = timer3_ovf_i;
            `ADCSEQ_SM_PIN: trigger = pin_rise;
            `ADCSEQ_SM_T2: trigger = timer2_ovf_i;
            default: trigger = 1'b0;
        endcase
    end

    // -------------------------------------------------------------------
    // Sequencer: optional track phase, then conversion.
    // -------------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            ST_IDLE: begin
                if (enable_w && !sleep_s2_reg && trigger) begin
                    cnt_next = 4'h0;
                    if (track_mode_select &&
                        start_mode_select != `ADCSEQ_SM_PIN) begin
                        state_next = ST_TRACK;
                    end else begin
                        state_next = ST_CONV;
                    end
                end
            end
            ST_TRACK: begin
                if (sar_tick) begin
                    cnt_next = cnt_reg + 4'h1;
                    if (cnt_reg == `ADCSEQ_TRACK_SAR_CLKS - 4'h1) begin
                        state_next = ST_CONV;
                        cnt_next = 4'h0;
                    end
                end
            end
            ST_CONV: begin
                if (sar_tick && cnt_reg != CONV_CLKS[3:0]) begin
                    cnt_next = cnt_reg + 4'h1;
                end
                if (sar_result_valid_i) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        // Clearing the enable bit drops any conversion at once.
        if (!enable_w) begin
            state_next = ST_IDLE;
        end
    end

    // -------------------------------------------------------------------
    // Result justification.
    // -------------------------------------------------------------------
    always @* begin
        if (left_justify) begin
            res_hi_next = sar_result_i[RES_W-1:RES_W-8];
            res_lo_next = {sar_result_i[RES_W-9:0], 6'h00};
        end else begin
            res_hi_next = {{6{sar_result_i[RES_W-1]}},
                sar_result_i[RES_W-1:RES_W-2]};
            res_lo_next = sar_result_i[7:0];
        end
    end

    // -------------------------------------------------------------------
    // State, registers and done flag.
    // -------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            busy_q_reg <= 1'b0;
            converter_control_reg <= `ADCSEQ_CTRL_RST;
            converter_config_reg <= `ADCSEQ_CFG_RST;
            result_high_reg <= `ADCSEQ_RES_HI_RST;
            result_low_reg <= `ADCSEQ_RES_LO_RST;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            busy_q_reg <= convert_busy;
            if (wr_ctrl) begin
                converter_control_reg <=
                    (sfr_wdata_i & `ADCSEQ_CTRL_WMASK) |
                    (converter_control_reg & ~`ADCSEQ_CTRL_WMASK);
            end
            // Setting the done flag wins over a software clear.
            if (busy_fall) begin
                converter_control_reg[`ADCSEQ_CTRL_DONE] <= 1'b1;
            end
            if (wr_cfg) begin
                converter_config_reg <= sfr_wdata_i;
            end
            // A finished conversion outranks a software write to the pair.
            if (state_reg == ST_CONV && sar_result_valid_i) begin
                result_high_reg <= res_hi_next;
                result_low_reg <= res_lo_next;
            end else if (wr_res_hi) begin
                result_high_reg <= sfr_wdata_i;
            end else if (wr_res_lo) begin
                result_low_reg <= sfr_wdata_i;
            end
        end
    end

    // Request stands while the done flag is set and the CPU enables it.
    assign irq_req_o = converter_control_reg[`ADCSEQ_CTRL_DONE] &&
        irq_enable_i;

    // -------------------------------------------------------------------
    // Analog-side outputs.
    // -------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            track_o <= 1'b0;
            sample_start_o <= 1'b0;
            sar_tick_o <= 1'b0;
        end else begin
            sar_tick_o <= sar_tick && state_reg == ST_CONV;
            sample_start_o <= state_reg != ST_CONV && state_next == ST_CONV;
            // Dark while disabled or asleep; else the track-mode bit picks
            // continuous tracking or the low-power timing of the start mode.
            if (!enable_w || sleep_s2_reg) begin
                track_o <= 1'b0;
            end else if (!track_mode_select) begin
                track_o <= state_next != ST_CONV;
            end else if (start_mode_select == `ADCSEQ_SM_PIN) begin
                track_o <= !pin_s2_reg && state_next != ST_CONV;
            end else begin
                track_o <= state_next == ST_TRACK;
            end
        end
    end

    // -------------------------------------------------------------------
    // Register read mux.
    // -------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (sfr_rd_i) begin
            case (sfr_addr_i)
                `ADCSEQ_ADDR_CTRL: begin
                    sfr_rdata_o <= converter_control_reg;
                    sfr_rdata_o[`ADCSEQ_CTRL_BUSY] <= convert_busy;
                end
                `ADCSEQ_ADDR_CFG: sfr_rdata_o <= converter_config_reg;
                `ADCSEQ_ADDR_RES_HI: sfr_rdata_o <= result_high_reg;
                `ADCSEQ_ADDR_RES_LO: sfr_rdata_o <= result_low_reg;
                default: sfr_rdata_o <= `ADCSEQ_RD_UNMAPPED;
            endcase
        end
    end

endmodule // adcseq_top

`default_nettype wire

// >>> dv/adcseq_top_sva.sv
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------------
// Port-level checks for the conversion sequencer.
// -----------------------------------------------------------------------
module adcseq_chk (
    input wire clk_i,
    input wire sys_rst_i,
    input wire sfr_wr_i,
    input wire irq_enable_i,
    input wire irq_req_o,
    input wire chip_sleep_i,
    input wire track_o,
    input wire sample_start_o,
    input wire sar_tick_o,
    input wire sar_result_valid_i
);
    reg conv_reg;
    reg [2:0] evt_reg;

    // Marks a conversion span and remembers recent causes of the done flag.
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            conv_reg <= 1'h0;
            evt_reg <= 3'h0;
        end else begin
            if (sar_result_valid_i) conv_reg <= 1'h0;
            else if (sample_start_o) conv_reg <= 1'h1;
            evt_reg <= {evt_reg[1:0], sar_result_valid_i | sfr_wr_i};
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_hold_no_track: assert property (
        (sample_start_o || conv_reg) |-> !track_o)
        else $error("Sampler tracks during a conversion.");
    a_start_pulse: assert property (
        sample_start_o |=> !sample_start_o)
        else $error("Start pulse lasts too long.");
    a_tick_gap: assert property (
        sar_tick_o |=> !sar_tick_o)
        else $error("SAR ticks closer than two clocks.");
    a_tick_soon: assert property (
        sample_start_o |-> ##[1:17] sar_tick_o)
        else $error("No SAR tick after the start pulse.");
    a_irq_gated: assert property (
        irq_req_o |-> irq_enable_i)
        else $error("Interrupt request while disabled.");
    a_irq_cause: assert property (
        $rose(irq_req_o) |-> $rose(irq_enable_i) || (|evt_reg))
        else $error("Interrupt request without a cause.");
    a_done_irq: assert property (
        conv_reg && sar_result_valid_i ##1 irq_enable_i [*3] |-> irq_req_o)
        else $error("Completed conversion raised no request.");
    a_sleep_dark: assert property (
        chip_sleep_i [*5] |-> !track_o)
        else $error("Sampler tracks during sleep.");
endmodule // adcseq_chk

`default_nettype wire

// >>> dv/adcseq_sar_model.sv
`timescale 1ns/1ps
`default_nettype none

// Sampler and SAR core: counts SAR clocks after the hold pulse.
// The reference is taken as settled before the first start.
module adcseq_sar_model #(
    parameter int TICKS = 12
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic sample_start_i,
    input wire logic sar_tick_i,
    input wire logic [9:0] code_i,
    output var logic [9:0] result_o = 10'h000,
    output var logic result_valid_o = 1'h0
);
    int cnt = 0;
    logic run = 1'h0;

    // Result lines toggle while idle so no stale code can pass unnoticed.
    always @(posedge clk_i) begin
        result_valid_o <= 1'h0;
        if (sys_rst_i) begin
            run <= 1'h0;
        end else if (sample_start_i) begin
            run <= 1'h1;
            cnt <= 0;
        end else if (run && sar_tick_i) begin
            cnt <= cnt + 1;
            if (cnt == TICKS - 1) begin
                run <= 1'h0;
                result_o <= code_i;
                result_valid_o <= 1'h1;
            end
        end else if (!run) begin
            result_o <= ~result_o;
        end
    end
endmodule // adcseq_sar_model

`default_nettype wire

// >>> dv/adcseq_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_defs.vh"

module adcseq_top_tb;
    logic clk_i = 1'h0, sys_rst_i = 1'h1, sfr_wr_i = 1'h0, sfr_rd_i = 1'h0;
    logic irq_enable_i = 1'h0, timer2_ovf_i = 1'h0, timer3_ovf_i = 1'h0;
    logic chip_sleep_i = 1'h0, convert_start_pin_i = 1'h1;
    logic irq_req_o, track_o, sample_start_o, sar_tick_o, sar_result_valid_i;
    logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00;
    logic [7:0] sfr_rdata_o, ctrl_v, rd_v;
    logic [9:0] sar_result_i, code = 10'h000;
    int mismatches = 0, compares = 0, seed = 44;

    adcseq_top #(.RES_W(10), .CONV_CLKS(12)) dut (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
        .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
        .sfr_rdata_o(sfr_rdata_o), .irq_enable_i(irq_enable_i),
        .irq_req_o(irq_req_o), .timer2_ovf_i(timer2_ovf_i),
        .timer3_ovf_i(timer3_ovf_i), .convert_start_pin_i(convert_start_pin_i),
        .chip_sleep_i(chip_sleep_i), .track_o(track_o),
        .sample_start_o(sample_start_o), .sar_tick_o(sar_tick_o),
        .sar_result_i(sar_result_i), .sar_result_valid_i(sar_result_valid_i));
    adcseq_sar_model #(.TICKS(12)) sar (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .sample_start_i(sample_start_o), .sar_tick_i(sar_tick_o),
        .code_i(code), .result_o(sar_result_i),
        .result_valid_o(sar_result_valid_i));

    // Free-running 200 MHz system clock.
    initial forever #2.5 clk_i = ~clk_i;

    function automatic logic [7:0] exp_hi(input logic [9:0] r, input logic lj);
        return lj ? r[9:2] : {{6{r[9]}}, r[9:8]};
    endfunction
    function automatic logic [7:0] exp_lo(input logic [9:0] r, input logic lj);
        return lj ? {r[1:0], 6'h00} : r[7:0];
    endfunction
    // Timed low-power tracking lasts three SAR clocks, plus the one cycle
    // in which the SAR clock divider restarts; other modes show none here.
    function automatic logic [9:0] exp_track(input logic tm,
            input logic [1:0] m, input logic [1:0] div);
        return (tm && m != 2'h2) ?
            10'(`ADCSEQ_TRACK_SAR_CLKS * (10'h2 << div) + 10'h1) : 10'h0;
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input string what, input logic [9:0] e, logic [9:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic give_verdict;
        $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic to_out;
        mismatches++;
        $display("MISMATCH wait expected event seen timeout");
        give_verdict();
    endtask
    // One idle cycle in front keeps strobes from being re-raised at once.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        step(1);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'h1;
        step(1);
        sfr_wr_i = 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        step(1);
        sfr_addr_i = a;
        sfr_rd_i = 1'h1;
        step(1);
        sfr_rd_i = 1'h0;
        rd_v = sfr_rdata_o;
    endtask
    task automatic quiet(input string what);
        int n = 0;
        repeat (30) begin
            step(1);
            n += (sample_start_o === 1'h1);
        end
        chk(what, 10'h0, 10'(n));
    endtask
    // Fires one start source: software, timer 3, pin edge or timer 2.
    task automatic fire(input logic [1:0] k);
        case (k)
            2'h0: wr(`ADCSEQ_ADDR_CTRL, ctrl_v | 8'h10);
            2'h1: begin
                timer3_ovf_i = 1'h1;
                step(1);
                timer3_ovf_i = 1'h0;
            end
            2'h2: begin
                convert_start_pin_i = 1'h0;
                step(4);
                if (ctrl_v[6] && ctrl_v[3:2] == 2'h2 && !chip_sleep_i)
                    chk("track_pin_low", 10'h1, track_o);
                convert_start_pin_i = 1'h1;
            end
            default: begin
                timer2_ovf_i = 1'h1;
                step(1);
                timer2_ovf_i = 1'h0;
            end
        endcase
    endtask
    task automatic do_conv(input logic [1:0] m, input logic tm, input logic lj,
            input logic [1:0] div, input logic [9:0] res);
        int n, t0, trk;
        code = res;
        irq_enable_i = ^res;
        wr(`ADCSEQ_ADDR_CFG, {6'h00, div});
        ctrl_v = {1'h1, tm, 2'h0, m, 1'h0, lj};
        wr(`ADCSEQ_ADDR_CTRL, ctrl_v);
        fire(m + 2'h1);
        quiet("stray_start");
        fire(m);
        trk = 0;
        for (n = 0; n < 400 && sample_start_o !== 1'h1; n++) begin
            trk += (track_o === 1'h1 && m != 2'h2);
            step(1);
        end
        if (n == 400) to_out();
        chk("track_cycles", exp_track(tm, m, div), 10'(trk));
        t0 = -1;
        for (n = 0; n < 40; n++) begin
            step(1);
            if (sar_tick_o === 1'h1 && t0 >= 0) break;
            if (sar_tick_o === 1'h1) t0 = n;
        end
        if (n == 40) to_out();
        chk("tick_gap", 10'h2 << div, 10'(n - t0));
        rd(`ADCSEQ_ADDR_CTRL);
        chk("busy_run", 10'h1, rd_v[4]);
        for (n = 0; n < 300; n++) begin
            rd(`ADCSEQ_ADDR_CTRL);
            if (rd_v[5] === 1'h1) break;
        end
        if (n == 300) to_out();
        chk("busy_end", 10'h0, rd_v[4]);
        chk("irq_req", irq_enable_i, irq_req_o);
        rd(`ADCSEQ_ADDR_RES_HI);
        chk("res_hi", exp_hi(res, lj), rd_v);
        rd(`ADCSEQ_ADDR_RES_LO);
        chk("res_lo", exp_lo(res, lj), rd_v);
        if (!tm) chk("track_idle", 10'h1, track_o);
        else if (m == 2'h2) chk("track_pin_high", 10'h0, track_o);
        else chk("track_low_power", 10'h0, track_o);
        wr(`ADCSEQ_ADDR_CTRL, ctrl_v);
        step(1);
        chk("irq_clear", 10'h0, irq_req_o);
        $display("Conversion mode %0d track %0d ended.", m, tm);
    endtask

    // Reset, register defaults, every mode and corner, random runs, sleep.
    initial begin
        logic [9:0] corner [4];
        logic [7:0] adr [5];
        logic [31:0] r;
        corner = '{10'h3FF, 10'h200, 10'h1FF, 10'h001};
        adr = '{`ADCSEQ_ADDR_CTRL, `ADCSEQ_ADDR_CFG, `ADCSEQ_ADDR_RES_HI,
            `ADCSEQ_ADDR_RES_LO, 8'h55};
        step(8);
        sys_rst_i = 1'h0;
        wr(8'h55, 8'hFF);
        foreach (adr[i]) begin
            rd(adr[i]);
            chk("reset_value", 10'h0, rd_v);
        end
        $display("Register defaults checked.");
        for (int i = 0; i < 8; i++) begin
            r = i;
            do_conv(r[1:0], r[2], ^r[2:0], r[1:0] ^ {2{r[2]}}, corner[i % 4]);
        end
        repeat (6) begin
            r = $random(seed);
            do_conv(r[1:0], r[2], r[3], r[5:4], r[15:6]);
        end
        chip_sleep_i = 1'h1;
        ctrl_v = 8'h84;
        wr(`ADCSEQ_ADDR_CTRL, ctrl_v);
        step(5);
        chk("sleep_track", 10'h0, track_o);
        fire(2'h1);
        quiet("sleep_start");
        chip_sleep_i = 1'h0;
        $display("Sleep test ended.");
        give_verdict();
    end
endmodule // adcseq_top_tb

bind adcseq_top adcseq_chk chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .sfr_wr_i(sfr_wr_i), .irq_enable_i(irq_enable_i), .irq_req_o(irq_req_o),
    .chip_sleep_i(chip_sleep_i), .track_o(track_o),
    .sample_start_o(sample_start_o), .sar_tick_o(sar_tick_o),
    .sar_result_valid_i(sar_result_valid_i));

`default_nettype wire
